//--- hdl/sps_map.svh
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH
`define SPS_SEG_BITS 4
`define SPS_NUM_SEG 16
`define SPS_ADDR_BITS 12
`define SPS_SAMP_BITS 16
`define SPS_RATE_BITS 16
`define SPS_GAIN_BITS 8
`define SPS_MARK_BITS 4
`define SPS_LIST_BITS 4
`define SPS_LIST_LEN 16
`define SPS_FIFO_DEPTH 32
`define SPS_FIFO_AW 5
`define SPS_GAIN_UNITY 8'h80
`define SPS_BLANK_SEG 4'hF
`define SPS_PHASE_RST 16'h0000
`endif

//--- hdl/sps_pkg.sv
`include "sps_map.svh"
package sps_pkg;
   typedef enum logic [1:0] {SPS_CLK_FILE = 2'h0, SPS_CLK_FAST = 2'h1,
                             SPS_CLK_CUSTOM = 2'h2} sps_clk_mode_t;
   typedef struct packed {
      logic [`SPS_SAMP_BITS-1:0] sample;
      logic [`SPS_MARK_BITS-1:0] marker;
      logic segStart;
      logic [`SPS_SEG_BITS-1:0] seg;
   } sps_out_t;
   typedef struct packed {
      logic [`SPS_ADDR_BITS-1:0] base;
      logic [`SPS_ADDR_BITS-1:0] length;
      logic [`SPS_RATE_BITS-1:0] rate;
      logic [`SPS_GAIN_BITS-1:0] gain;
   } sps_seg_desc_t;
endpackage

//--- hdl/segment_playback_sequencer.sv
`timescale 1ns/100ps
`include "sps_map.svh"
// Operation
// - Internal source: switch only on execute command or selected-segment write.
// - External source: trigger input requests each switch.
// - Writing selected segment switches there, internally, in abrupt mode only.
// - Default order: next higher index, from first.
// - Active play list supplies next segment.
// - Abrupt mode: stop now, next from start.
// - Seamless mode: wait for last sample, gapless.
// - Seamless refused in per-file clock unless all rates equal.
// - Differing rates, per-file clock, abrupt: internal source only.
// - Index selects and orders segments.
// - Per-file clock: segment's own rate.
// - Fastest clock: highest available rate for all.
// - Custom clock: programmed custom rate for all.
// - Keep level: samples output unscaled.
// - Equalize level: scale segments to equal RMS.
// - Marker ignore: suppress stored marker bits.
// - Marker keep: pass stored marker bits.
// - Restart marker off or output 1-4, first segment.
// - Restart marker enabled overrides stored markers.
// - Blank segment: programmable count and rate.
// - Blank segment outputs zero samples.
// - After last segment, wrap to first.
// - Every segment start raises segment-start marker.

// ----------------------------------------------------------------
// Output FIFO
// ----------------------------------------------------------------
module sps_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32,
   parameter int AW = 5
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr_q;
   logic [AW:0] rdPtr_q;
   logic full;
   logic empty;
   assign full = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
   assign empty = (wrPtr_q == rdPtr_q);
   assign inReady = !full;
   assign outValid = !empty;
   assign outData = mem[rdPtr_q[AW-1:0]];
   always_ff @(posedge clk_sys)
   begin
      if (inValid && !full)
      begin
         mem[wrPtr_q[AW-1:0]] <= inData;
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end
      else
      begin
         if (inValid && !full)
         begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (outReady && !empty)
         begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
      end
   end
endmodule

// ----------------------------------------------------------------
// Sequencer
// ----------------------------------------------------------------
module segment_playback_sequencer (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic srcExternal,
   input wire logic execSwitch,
   input wire logic [`SPS_SEG_BITS-1:0] selSeg,
   input wire logic selSegWrite,
   input wire logic seamlessReq,
   input wire logic playListEn,
   input wire logic [`SPS_LIST_BITS-1:0] playListLen,
   input wire logic listWrite,
   input wire logic [`SPS_LIST_BITS-1:0] listWrIdx,
   input wire logic [`SPS_SEG_BITS-1:0] listWrSeg,
   input wire logic [`SPS_SEG_BITS-1:0] numSegs,
   input wire logic descWrite,
   input wire logic [`SPS_SEG_BITS-1:0] descWrIdx,
   input wire sps_pkg::sps_seg_desc_t descWrData,
   input wire logic [`SPS_ADDR_BITS-1:0] blankSamples,
   input wire logic [`SPS_RATE_BITS-1:0] blankRate,
   input wire sps_pkg::sps_clk_mode_t clkMode,
   input wire logic [`SPS_RATE_BITS-1:0] customRate,
   input wire logic [`SPS_RATE_BITS-1:0] fastRate,
   input wire logic equalizeLevel,
   input wire logic markerKeep,
   input wire logic [2:0] restartMarkerSel,
   input wire logic extTrigger,
   output logic memRdEn,
   output logic [`SPS_ADDR_BITS-1:0] memRdAddr,
   input wire logic [`SPS_SAMP_BITS-1:0] memRdSample,
   input wire logic [`SPS_MARK_BITS-1:0] memRdMarker,
   output sps_pkg::sps_out_t outData,
   output logic outValid,
   input wire logic outReady,
   output logic [`SPS_SEG_BITS-1:0] currentSeg,
   output logic seamlessActive,
   output logic ratesEqual
);
   sps_pkg::sps_seg_desc_t desc_q [`SPS_NUM_SEG];
   logic [`SPS_SEG_BITS-1:0] playList_q [`SPS_LIST_LEN];
   logic [`SPS_SEG_BITS-1:0] seg_q;
   logic [`SPS_LIST_BITS-1:0] listPos_q;
   logic [`SPS_ADDR_BITS-1:0] sampIdx_q;
   logic [`SPS_RATE_BITS:0] phase_q;
   logic pending_q;
   logic first_q;
   logic started_q;
   logic trigS1_q;
   logic trigS2_q;
   logic trigS3_q;
   logic rdValid_q;
   logic rdStart_q;
   logic rdBlank_q;
   logic rdSeqStart_q;
   logic [`SPS_SEG_BITS-1:0] rdSeg_q;
   logic [`SPS_GAIN_BITS-1:0] rdGain_q;
   logic [`SPS_FIFO_AW:0] fill_q;
   logic room;
   logic [`SPS_RATE_BITS-1:0] rate;
   logic [`SPS_ADDR_BITS-1:0] segLen;
   logic isBlank;
   logic tick;
   logic lastSample;
   logic extEvent;
   logic switchEvent;
   logic doSwitch;
   logic [`SPS_SEG_BITS-1:0] nextSeg;
   logic fifoInReady;
   logic [`SPS_SAMP_BITS-1:0] scaled;
   logic [`SPS_MARK_BITS-1:0] markOut;
   sps_pkg::sps_out_t fifoIn;

   function automatic logic [`SPS_SEG_BITS-1:0] incSeg(input logic [`SPS_SEG_BITS-1:0] s,
                                                        input logic [`SPS_SEG_BITS-1:0] n);
      incSeg = (s + 1'b1 >= n) ? '0 : s + 1'b1;
   endfunction

   // --------------------------------------------------------------
   // Configuration tables
   // --------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (descWrite)
      begin
         desc_q[descWrIdx] <= descWrData;
      end
      if (listWrite)
      begin
         playList_q[listWrIdx] <= listWrSeg;
      end
   end

   // Rates are compared across the loaded segments only; the check is combinational.
   always_comb
   begin
      ratesEqual = 1'b1;
      for (int i = 1; i < `SPS_NUM_SEG; i++)
      begin
         if ((i < int'(numSegs)) && (desc_q[i].rate != desc_q[0].rate))
         begin
            ratesEqual = 1'b0;
         end
      end
   end

   // Fixed-rate policies resample offline, so rates are treated as equal.
   assign seamlessActive = seamlessReq &&
      (ratesEqual || clkMode != sps_pkg::SPS_CLK_FILE);

   // --------------------------------------------------------------
   // Switch events
   // --------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         trigS1_q <= 1'b0;
         trigS2_q <= 1'b0;
         trigS3_q <= 1'b0;
      end
      else
      begin
         trigS1_q <= extTrigger;
         trigS2_q <= trigS1_q;
         trigS3_q <= trigS2_q;
      end
   end
   assign extEvent = trigS2_q && !trigS3_q;

   always_comb
   begin
      if (srcExternal)
      begin
         // Differing per-file rates leave only internal switching in abrupt mode.
         switchEvent = extEvent &&
            !(clkMode == sps_pkg::SPS_CLK_FILE && !ratesEqual && !seamlessActive);
      end
      else
      begin
         switchEvent = execSwitch || selSegWrite;
      end
   end

   always_comb
   begin
      if (!srcExternal && selSegWrite)
      begin
         nextSeg = selSeg;
      end
      else if (playListEn)
      begin
         nextSeg = playList_q[incSeg(listPos_q, playListLen)];
      end
      else
      begin
         nextSeg = incSeg(seg_q, numSegs);
      end
   end

   // --------------------------------------------------------------
   // Playback rate and position
   // --------------------------------------------------------------
   assign isBlank = (seg_q == `SPS_BLANK_SEG);
   always_comb
   begin
      unique case (clkMode)
         sps_pkg::SPS_CLK_FAST: rate = fastRate;
         sps_pkg::SPS_CLK_CUSTOM: rate = customRate;
         default: rate = isBlank ? blankRate : desc_q[seg_q].rate;
      endcase
   end
   assign segLen = isBlank ? blankSamples : desc_q[seg_q].length;

   // Rate is a fraction of clk_sys in 1/65536 steps; overflow of the accumulator ticks.
   // The word of a tick reaches the FIFO one cycle later, so the word in flight counts too.
   assign room = (fill_q + {5'h0, rdValid_q}) < 6'(`SPS_FIFO_DEPTH);
   assign tick = phase_q[`SPS_RATE_BITS] && room;
   assign lastSample = (sampIdx_q + 1'b1 >= segLen);
   assign doSwitch = seamlessActive ? ((pending_q || switchEvent) && tick && lastSample)
                                    : switchEvent;

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         phase_q <= '0;
      end
      else if (!phase_q[`SPS_RATE_BITS] || room)
      begin
         phase_q <= {1'b0, phase_q[`SPS_RATE_BITS-1:0]} + {1'b0, rate};
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         fill_q <= '0;
      end
      else
      begin
         fill_q <= fill_q + {5'h0, rdValid_q && fifoInReady} - {5'h0, outValid && outReady};
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         pending_q <= 1'b0;
      end
      else if (doSwitch || !seamlessActive)
      begin
         // A request left over from seamless mode must not fire later on its own.
         pending_q <= 1'b0;
      end
      else if (seamlessActive && switchEvent)
      begin
         pending_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         seg_q <= '0;
         listPos_q <= '0;
         sampIdx_q <= '0;
         started_q <= 1'b1;
         first_q <= 1'b1;
      end
      else
      begin
         if (doSwitch)
         begin
            seg_q <= nextSeg;
            sampIdx_q <= '0;
            started_q <= 1'b1;
            first_q <= (nextSeg == '0);
            if (playListEn && !selSegWrite)
            begin
               listPos_q <= incSeg(listPos_q, playListLen);
            end
         end
         else if (tick)
         begin
            started_q <= 1'b0;
            if (lastSample)
            begin
               sampIdx_q <= '0;
               started_q <= 1'b1;
               first_q <= (seg_q == '0);
            end
            else
            begin
               sampIdx_q <= sampIdx_q + 1'b1;
            end
         end
      end
   end

   // --------------------------------------------------------------
   // Memory read and sample shaping
   // --------------------------------------------------------------
   assign memRdEn = tick && !isBlank;
   assign memRdAddr = desc_q[seg_q].base + sampIdx_q;

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         rdValid_q <= 1'b0;
         rdStart_q <= 1'b0;
         rdBlank_q <= 1'b0;
         rdSeqStart_q <= 1'b0;
         rdSeg_q <= '0;
         rdGain_q <= `SPS_GAIN_UNITY;
      end
      else
      begin
         rdValid_q <= tick;
         rdStart_q <= started_q;
         rdBlank_q <= isBlank;
         rdSeqStart_q <= started_q && first_q;
         rdSeg_q <= seg_q;
         rdGain_q <= equalizeLevel ? desc_q[seg_q].gain : `SPS_GAIN_UNITY;
      end
   end

   // Gain is Q1.7; the product is truncated, trading a little precision for one multiplier.
   always_comb
   begin
      logic [`SPS_SAMP_BITS+`SPS_GAIN_BITS-1:0] prod;
      prod = '0;
      prod = memRdSample * rdGain_q;
      scaled = rdBlank_q ? '0 : prod[`SPS_SAMP_BITS+`SPS_GAIN_BITS-2 -: `SPS_SAMP_BITS];
   end

   always_comb
   begin
      markOut = (markerKeep && !rdBlank_q) ? memRdMarker : '0;
      if (restartMarkerSel != 3'h0)
      begin
         markOut = '0;
         if (restartMarkerSel <= 3'h4)
         begin
            markOut[restartMarkerSel[1:0] - 2'h1] = rdSeqStart_q;
         end
      end
   end

   assign fifoIn.sample = scaled;
   assign fifoIn.marker = markOut;
   assign fifoIn.segStart = rdStart_q;
   assign fifoIn.seg = rdSeg_q;
   assign currentSeg = seg_q;

   sps_fifo #(
      .WIDTH($bits(sps_pkg::sps_out_t)),
      .DEPTH(`SPS_FIFO_DEPTH),
      .AW(`SPS_FIFO_AW)
   ) u_fifo (
      .clk_sys(clk_sys),
      .srst(srst),
      .inData(fifoIn),
      .inValid(rdValid_q),
      .inReady(fifoInReady),
      .outData(outData),
      .outValid(outValid),
      .outReady(outReady)
   );
endmodule

//--- tb/sps_monitor.sv
`timescale 1ns/100ps
`include "sps_map.svh"
// ----------------------------------------
// Port checks of the sequencer
// ----------------------------------------
module sps_monitor (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic srcExternal,
   input wire logic execSwitch,
   input wire logic [`SPS_SEG_BITS-1:0] selSeg,
   input wire logic selSegWrite,
   input wire logic seamlessReq,
   input wire logic playListEn,
   input wire logic [`SPS_SEG_BITS-1:0] numSegs,
   input wire sps_pkg::sps_clk_mode_t clkMode,
   input wire logic extTrigger,
   input wire sps_pkg::sps_out_t outData,
   input wire logic outValid,
   input wire logic outReady,
   input wire logic [`SPS_SEG_BITS-1:0] currentSeg,
   input wire logic seamlessActive,
   input wire logic ratesEqual
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   sequence s_intCmd;
      !srcExternal && !seamlessActive;
   endsequence
   // Five quiet samples outlast the trigger synchroniser and edge detector.
   sequence s_trigIdle;
      !extTrigger [*5];
   endsequence
   sequence s_trigRise;
      $rose(extTrigger) && srcExternal && !seamlessActive && clkMode != sps_pkg::SPS_CLK_FILE;
   endsequence
   property p_noCmd;
      s_intCmd ##0 (!execSwitch && !selSegWrite) |=> $stable(currentSeg);
   endproperty
   property p_jump;
      s_intCmd ##0 selSegWrite |=> currentSeg == $past(selSeg);
   endproperty
   property p_step;
      s_intCmd ##0 (execSwitch && !selSegWrite && !playListEn && currentSeg < numSegs)
      |=> currentSeg == (($past(currentSeg) + 4'h1 == $past(numSegs)) ? 4'h0
                         : $past(currentSeg) + 4'h1);
   endproperty
   property p_grant;
      seamlessActive == (seamlessReq && (clkMode != sps_pkg::SPS_CLK_FILE || ratesEqual));
   endproperty
   property p_extDrop;
      srcExternal && clkMode == sps_pkg::SPS_CLK_FILE && !ratesEqual && !seamlessActive
      |=> $stable(currentSeg);
   endproperty
   property p_extQuiet;
      s_trigIdle ##0 (srcExternal && !seamlessActive) |=> $stable(currentSeg);
   endproperty
   property p_extTake;
      s_trigRise |-> ##[1:5] currentSeg != $past(currentSeg);
   endproperty
   property p_blank;
      outValid && outData.seg == `SPS_BLANK_SEG |-> outData.sample == 16'h0000;
   endproperty
   property p_hold;
      outValid && !outReady |=> outValid && $stable(outData);
   endproperty
   a_noCmd: assert property (p_noCmd) else $error("segment changed without command");
   a_jump: assert property (p_jump) else $error("jump did not reach selected segment");
   a_step: assert property (p_step) else $error("switch did not step to next index");
   a_grant: assert property (p_grant) else $error("seamless grant wrong");
   a_extDrop: assert property (p_extDrop) else $error("external switch not refused");
   a_extQuiet: assert property (p_extQuiet) else $error("switch without trigger edge");
   a_extTake: assert property (p_extTake) else $error("trigger edge not taken");
   a_blank: assert property (p_blank) else $error("blank segment sample not zero");
   a_hold: assert property (p_hold) else $error("output word changed while stalled");
endmodule
bind segment_playback_sequencer sps_monitor sps_monitor_i (.clk_sys, .srst, .srcExternal,
   .execSwitch, .selSeg, .selSegWrite, .seamlessReq, .playListEn, .numSegs, .clkMode,
   .extTrigger, .outData, .outValid, .outReady, .currentSeg, .seamlessActive, .ratesEqual);

//--- tb/sps_far_side.sv
`timescale 1ns/100ps
`include "sps_map.svh"
// ----------------------------------------
// Waveform memory, trigger source and sink
// ----------------------------------------
module sps_far_side (
   input wire logic clk_sys,
   input wire logic memRdEn,
   input wire logic [`SPS_ADDR_BITS-1:0] memRdAddr,
   output logic [`SPS_SAMP_BITS-1:0] memRdSample = 16'h0000,
   output logic [`SPS_MARK_BITS-1:0] memRdMarker = 4'h0,
   input wire logic trigReq,
   output logic extTrigger = 1'b0,
   input wire logic stall,
   output logic outReady = 1'b1
);
   logic [2:0] trigCnt = 3'h0;
   // Data not read this cycle is inverted so a sample taken one cycle late cannot pass.
   always @(posedge clk_sys)
   begin
      memRdSample <= memRdEn ? {4'h0, memRdAddr} : ~memRdSample;
      memRdMarker <= memRdEn ? memRdAddr[3:0] : ~memRdMarker;
      outReady <= !stall;
   end
   always @(posedge clk_sys)
   begin
      trigCnt <= trigReq ? 3'h4 : (trigCnt != 3'h0 ? trigCnt - 3'h1 : 3'h0);
      extTrigger <= trigReq || trigCnt > 3'h1;
   end
endmodule

//--- tb/tb.sv
`timescale 1ns/100ps
`include "sps_map.svh"
// ----------------------------------------
// Sequencer testbench
// ----------------------------------------
module tb;
   logic clk_sys = 1'b0, srst = 1'b1, srcExternal = 1'b0, execSwitch = 1'b0;
   logic selSegWrite = 1'b0, seamlessReq = 1'b0, playListEn = 1'b0, listWrite = 1'b0;
   logic descWrite = 1'b0, equalizeLevel = 1'b0, markerKeep = 1'b0, trigReq = 1'b0;
   logic stall = 1'b0, memRdEn, extTrigger, outReady, outValid, seamlessActive, ratesEqual;
   logic [3:0] selSeg = 4'h0, playListLen = 4'h0, listWrIdx = 4'h0, listWrSeg = 4'h0;
   logic [3:0] numSegs = 4'h4, descWrIdx = 4'h0, currentSeg, memRdMarker;
   logic [11:0] blankSamples = 12'h003, memRdAddr;
   logic [15:0] blankRate = 16'h8000, customRate = 16'h8000, fastRate = 16'hFFFF;
   logic [15:0] memRdSample;
   logic [2:0] restartMarkerSel = 3'h0;
   sps_pkg::sps_clk_mode_t clkMode = sps_pkg::SPS_CLK_FAST;
   sps_pkg::sps_seg_desc_t descWrData = '0;
   sps_pkg::sps_out_t outData;
   sps_pkg::sps_out_t q[$];
   int error_cnt = 0, checks = 0, cyc = 0;
   segment_playback_sequencer segment_playback_sequencer_i (.clk_sys, .srst, .srcExternal,
      .execSwitch, .selSeg, .selSegWrite, .seamlessReq, .playListEn, .playListLen, .listWrite,
      .listWrIdx, .listWrSeg, .numSegs, .descWrite, .descWrIdx, .descWrData, .blankSamples,
      .blankRate, .clkMode, .customRate, .fastRate, .equalizeLevel, .markerKeep,
      .restartMarkerSel, .extTrigger, .memRdEn, .memRdAddr, .memRdSample, .memRdMarker,
      .outData, .outValid, .outReady, .currentSeg, .seamlessActive, .ratesEqual);
   sps_far_side sps_far_side_i (.clk_sys, .memRdEn, .memRdAddr, .memRdSample, .memRdMarker,
      .trigReq, .extTrigger, .stall, .outReady);
   always #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
      if (outValid && outReady) q.push_back(outData);
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         stop_test();
      end
   end
   task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic exec();
      @(posedge clk_sys) execSwitch <= 1'b1;
      @(posedge clk_sys) execSwitch <= 1'b0;
      tick(3);
   endtask
   task automatic jump(logic [3:0] s);
      @(posedge clk_sys) selSeg <= s;
      selSegWrite <= 1'b1;
      @(posedge clk_sys) selSegWrite <= 1'b0;
      tick(3);
      chk("currentSeg", currentSeg, s);
   endtask
   task automatic grab(logic [3:0] s, output int k);
      k = -1;
      for (int t = 0; t < 600 && (k < 0 || q.size() < k + 12); t++)
      begin
         @(posedge clk_sys);
         if (k < 0) foreach (q[i]) if (k < 0 && q[i].seg === s) k = i;
      end
      chk("found", k >= 0, 1);
   endtask
   // Expects words of segment s from its start: mm 0 no marker, 1 stored, 2 restart.
   task automatic run(logic [3:0] s, int mm, int sh);
      int k;
      logic [3:0] m;
      logic [15:0] v;
      q.delete();
      jump(s);
      grab(s, k);
      for (int j = 0; j < 8; j++)
      begin
         v = ({4'h0, s, 8'h00} | 16'(j % 4)) >> sh;
         m = mm == 1 ? 4'(j % 4) : (mm == 2 && j % 4 == 0) ? 4'h2 : 4'h0;
         chk("word", {q[k+j].segStart, q[k+j].marker, q[k+j].sample}, {j % 4 == 0, m, v});
      end
   endtask
   task automatic rate(int lo, int hi);
      int n = 0;
      tick(40);
      repeat (64) @(posedge clk_sys) n += memRdEn;
      chk("ticks", n >= lo && n <= hi, 1);
   endtask
   task automatic t_step();
      tick(20);
      chk("currentSeg", currentSeg, 0);
      for (int i = 1; i < 6; i++)
      begin
         exec();
         chk("currentSeg", currentSeg, i % 4);
      end
      $display("test step done");
   endtask
   task automatic t_words();
      run(4'h2, 0, 0);
      run(4'h1, 0, 0);
      markerKeep <= 1'b1;
      run(4'h3, 1, 0);
      markerKeep <= 1'b0;
      equalizeLevel <= 1'b1;
      run(4'h1, 0, 1);
      equalizeLevel <= 1'b0;
      markerKeep <= 1'b1;
      restartMarkerSel <= 3'h2;
      run(4'h0, 2, 0);
      restartMarkerSel <= 3'h0;
      markerKeep <= 1'b0;
      $display("test words done");
   endtask
   task automatic t_ext();
      srcExternal <= 1'b1;
      @(posedge clk_sys) trigReq <= 1'b1;
      @(posedge clk_sys) trigReq <= 1'b0;
      tick(12);
      chk("currentSeg", currentSeg, 1);
      exec();
      chk("currentSeg", currentSeg, 1);
      clkMode <= sps_pkg::SPS_CLK_FILE;
      @(posedge clk_sys) trigReq <= 1'b1;
      @(posedge clk_sys) trigReq <= 1'b0;
      tick(12);
      chk("ratesEqual", ratesEqual, 0);
      chk("currentSeg", currentSeg, 1);
      srcExternal <= 1'b0;
      $display("test ext done");
   endtask
   task automatic t_seamless();
      int k;
      seamlessReq <= 1'b1;
      tick(2);
      chk("seamlessActive", seamlessActive, 0);
      clkMode <= sps_pkg::SPS_CLK_CUSTOM;
      stall <= 1'b1;
      tick(100);
      chk("memRdEn", memRdEn, 0);
      q.delete();
      chk("seamlessActive", seamlessActive, 1);
      exec();
      tick(20);
      chk("currentSeg", currentSeg, 1);
      stall <= 1'b0;
      grab(4'h2, k);
      chk("last", {q[k-1].seg, q[k-1].sample}, {4'h1, 16'h0103});
      chk("first", {q[k].segStart, q[k].sample}, {1'b1, 16'h0200});
      seamlessReq <= 1'b0;
      $display("test seamless done");
   endtask
   task automatic t_blank();
      int k;
      q.delete();
      jump(`SPS_BLANK_SEG);
      grab(`SPS_BLANK_SEG, k);
      for (int j = 0; j < 6; j++)
         chk("blank", {q[k+j].segStart, q[k+j].sample}, {j % 3 == 0, 16'h0000});
      $display("test blank done");
   endtask
   task automatic t_list();
      logic [3:0] v[3];
      logic [3:0] l[3] = '{4'h3, 4'h0, 4'h2};
      int p = -1;
      jump(4'h1);
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk_sys) listWrite <= 1'b1;
         listWrIdx <= 4'(i);
         listWrSeg <= l[i];
      end
      @(posedge clk_sys) listWrite <= 1'b0;
      playListLen <= 4'h3;
      playListEn <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         exec();
         v[i] = currentSeg;
         if (l[i] === v[0]) p = i;
      end
      chk("listStart", p >= 0, 1);
      chk("list1", v[1], l[(p + 1) % 3]);
      chk("list2", v[2], l[(p + 2) % 3]);
      playListEn <= 1'b0;
      $display("test list done");
   endtask
   task automatic t_rate();
      customRate <= 16'h4000;
      rate(15, 17);
      clkMode <= sps_pkg::SPS_CLK_FILE;
      jump(4'h0);
      rate(31, 33);
      clkMode <= sps_pkg::SPS_CLK_FAST;
      rate(62, 64);
      $display("test rate done");
   endtask
   initial
   begin
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      #1;
      chk("resetSeg", {outValid, currentSeg}, 0);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk_sys) descWrite <= 1'b1;
         descWrIdx <= 4'(i);
         descWrData <= '{12'(i * 256), 12'h004, i == 1 ? 16'h4000 : 16'h8000,
                         i == 1 ? 8'h40 : 8'h80};
      end
      @(posedge clk_sys) descWrite <= 1'b0;
      t_step();
      t_words();
      t_ext();
      t_seamless();
      t_blank();
      t_list();
      t_rate();
      stop_test();
   end
endmodule
